// ===== twh_table_write_unit.v
// Table write holding unit: decodes table write, updates pointer, fills
// the holding bank. Assumes the core's fetch presents one word per cycle
// with i_instr_valid, from logic on the same clock.
//
// Contract
// - Decode fixed upper pattern plus mode field.
// - Pointer low three bits select holding register.
// - Copy table latch into selected holding register.
// - Holding registers stage data for programming.
// - Table pointer is 21 bits wide.
// - Pointer bit 0 picks low/high byte.
// - Plain mode leaves pointer unchanged.
// - Post modes write then step pointer.
// - Program-counter change takes second no-operation cycle.
// - Unused second words execute as no-operation.
`timescale 1ns/1ns
`default_nettype none
`include "twh_map.vh"

module twh_table_write_unit #(
   parameter PW = `TWH_PTR_W,
   parameter N  = `TWH_HOLD_N,
   parameter SW = `TWH_SEL_W
) (
   // Clock and reset
   input  wire           i_sys_clk,
   input  wire           i_rst_n,
   // Instruction stream
   input  wire           i_instr_valid,
   input  wire [15:0]    i_instr,
   input  wire           i_is_two_word,
   input  wire           i_word2_used,
   input  wire           i_pc_change,
   // Table pointer and latch loads from the core
   input  wire           i_ptr_load,
   input  wire [PW-1:0]  i_ptr_data,
   input  wire           i_latch_load,
   input  wire [7:0]     i_latch_data,
   input  wire [7:0]     i_status_in,
   // Programming side
   input  wire           i_hold_clear,
   input  wire [SW-1:0]  i_hold_rd_sel,
   output wire [7:0]     o_hold_rd_data,
   output wire [N*8-1:0] o_hold_all,
   // Status
   output reg  [PW-1:0]  o_table_pointer,
   output reg  [7:0]     o_table_latch,
   output reg  [7:0]     o_status,
   output reg            o_byte_high,
   output wire           o_busy,
   output reg            o_no_operation,
   output reg            o_write_done
);

   // ==========================================
   // Decode
   localparam ST_IDLE   = 3'b001;
   localparam ST_EXEC2  = 3'b010;
   localparam ST_SKIPW2 = 3'b100;

   // Detects the table write opcode
   function is_table_write_instr;
      input [15:0] w;
      begin
         is_table_write_instr = (w[`TWH_OP_UPPER_MSB:`TWH_OP_UPPER_LSB] == `TWH_OP_UPPER);
      end
   endfunction

   reg [2:0]    state_r;
   reg [2:0]    state_nxt;
   reg          wr_nxt;
   reg [PW-1:0] ptr_nxt;
   reg [PW-1:0] wr_ptr;
   reg [1:0]    mode;
   wire         hit;

   assign hit = i_instr_valid && (state_r == ST_IDLE) && is_table_write_instr(i_instr);
   assign o_busy = (state_r != ST_IDLE);

   // Next-state and pointer arithmetic
   always @* begin
      state_nxt = state_r;
      wr_nxt    = 1'b0;
      ptr_nxt   = o_table_pointer;
      wr_ptr    = o_table_pointer;
      mode      = i_instr[`TWH_OP_MODE_MSB:`TWH_OP_MODE_LSB];
      case (state_r)
         ST_IDLE: begin
            if (hit) begin
               wr_nxt    = 1'b1;
               state_nxt = ST_EXEC2;
               case (mode)
                  `TWH_MODE_NONE: ptr_nxt = o_table_pointer;
                  `TWH_MODE_POSTINC: ptr_nxt = o_table_pointer + `TWH_PTR_ONE;
                  `TWH_MODE_POSTDEC: ptr_nxt = o_table_pointer - `TWH_PTR_ONE;
                  `TWH_MODE_PREINC: begin
                     ptr_nxt = o_table_pointer + `TWH_PTR_ONE;
                     wr_ptr  = ptr_nxt;
                  end
                  default: ptr_nxt = o_table_pointer;
               endcase
            end else if (i_instr_valid && i_pc_change) begin
               state_nxt = ST_EXEC2;
            end else if (i_instr_valid && i_is_two_word && !i_word2_used) begin
               state_nxt = ST_SKIPW2;
            end
         end
         ST_EXEC2: state_nxt = ST_IDLE;
         ST_SKIPW2: begin
            if (i_instr_valid) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // ==========================================
   // Registers
   // 21-bit pointer state
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r         <= ST_IDLE;
         o_table_pointer <= `TWH_PTR_RST;
         o_table_latch   <= `TWH_LATCH_RST;
         o_status        <= `TWH_STATUS_RST;
         o_byte_high     <= 1'b0;
         o_no_operation  <= 1'b0;
         o_write_done    <= 1'b0;
      end else begin
         state_r        <= state_nxt;
         o_no_operation <= (state_r != ST_IDLE);
         o_write_done   <= wr_nxt;
         o_status       <= i_status_in;
         if (i_latch_load) begin
            o_table_latch <= i_latch_data;
         end
         if (wr_nxt) begin
            o_table_pointer <= ptr_nxt;
            o_byte_high     <= wr_ptr[0];
         end else if (i_ptr_load) begin
            o_table_pointer <= i_ptr_data;
            o_byte_high     <= i_ptr_data[0];
         end
      end
   end

   // ==========================================
   // Holding bank
   // low bits select; latch copied; staging bank
   twh_hold_bank #(
      .N  (N),
      .SW (SW)
   ) u_bank (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_wr      (wr_nxt),
      .i_sel     (wr_ptr[SW-1:0]),
      .i_data    (o_table_latch),
      .i_clear   (i_hold_clear),
      .i_rd_sel  (i_hold_rd_sel),
      .o_rd_data (o_hold_rd_data),
      .o_all     (o_hold_all)
   );

endmodule // twh_table_write_unit
`default_nettype wire

// ===== twh_map.vh
// Constants for the table write holding unit.
// Assumes inclusion by the unit's design files only.
`ifndef TWH_MAP_VH
`define TWH_MAP_VH

// ==========================================
// Opcode layout
`define TWH_OP_UPPER      14'h0003
`define TWH_OP_UPPER_MSB  15
`define TWH_OP_UPPER_LSB  2
`define TWH_OP_MODE_MSB   1
`define TWH_OP_MODE_LSB   0

// ==========================================
// Pointer update modes
`define TWH_MODE_NONE     2'h0
`define TWH_MODE_POSTINC  2'h1
`define TWH_MODE_POSTDEC  2'h2
`define TWH_MODE_PREINC   2'h3

// ==========================================
// Widths and reset values
`define TWH_PTR_W         21
`define TWH_SEL_W         3
`define TWH_HOLD_N        8
`define TWH_PTR_RST       21'h000000
`define TWH_BYTE_RST      8'hff
`define TWH_LATCH_RST     8'h00
`define TWH_STATUS_RST    8'h00
`define TWH_PTR_ONE       21'h000001

`endif

// ===== twh_hold_bank.v
// Holding register bank: eight byte registers staged for flash programming.
// Assumes one write strobe per cycle from the table write decoder.
`timescale 1ns/1ns
`default_nettype none
`include "twh_map.vh"

module twh_hold_bank #(
   parameter N  = `TWH_HOLD_N,
   parameter SW = `TWH_SEL_W
) (
   // Clock and reset
   input  wire           i_sys_clk,
   input  wire           i_rst_n,
   // Write side
   input  wire           i_wr,
   input  wire [SW-1:0]  i_sel,
   input  wire [7:0]     i_data,
   // Programming side
   input  wire           i_clear,
   input  wire [SW-1:0]  i_rd_sel,
   output reg  [7:0]     o_rd_data,
   output wire [N*8-1:0] o_all
);

   // ==========================================
   // Storage
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_byte
         reg [7:0] byte_r;
         // One byte: written when selected, erased after programming
         always @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               byte_r <= `TWH_BYTE_RST;
            end else if (i_wr && (i_sel == g)) begin
               byte_r <= i_data;
            end else if (i_clear) begin
               byte_r <= `TWH_BYTE_RST;
            end
         end
         assign o_all[g*8 +: 8] = byte_r;
      end
   endgenerate

   // Registered read port
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rd_data <= `TWH_BYTE_RST;
      end else begin
         o_rd_data <= o_all[i_rd_sel*8 +: 8];
      end
   end

endmodule // twh_hold_bank
`default_nettype wire

// ===== twh_monitor.sv
// Port checker for the table write unit.
// Assumes one clock and an async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module twh_monitor (
   // Watched ports
   input wire logic        i_sys_clk, i_rst_n, i_instr_valid, i_is_two_word,
   input wire logic        i_word2_used, i_pc_change, i_ptr_load, o_busy,
   input wire logic        o_no_operation, o_write_done, o_byte_high,
   input wire logic [15:0] i_instr,
   input wire logic [20:0] i_ptr_data, o_table_pointer,
   input wire logic [7:0]  i_status_in, o_status, o_table_latch,
   input wire logic [63:0] o_hold_all
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   // Table write taken at this edge
   wire       take = i_instr_valid && !o_busy && i_instr[15:2] == 14'h0003;
   wire [1:0] md   = i_instr[1:0];
   logic [2:0] sel_r;
   // Slot that the write lands in
   always_ff @(posedge i_sys_clk)
      sel_r <= o_table_pointer[2:0] + {2'h0, md == 2'h3};
   sequence s_dummy;
      o_busy ##1 (o_no_operation && !o_busy);
   endsequence
   a_write_two_cyc: assert property (take |=> o_write_done ##0 s_dummy)
      else $error("table write timing wrong");
   a_ptr_kept: assert property (take && md == 2'h0 |=> $stable(o_table_pointer))
      else $error("pointer moved");
   a_ptr_step_up: assert property (take && md[0] |=> o_table_pointer == $past(o_table_pointer) + 21'h1)
      else $error("pointer not incremented");
   a_ptr_step_down: assert property (take && md == 2'h2 |=> o_table_pointer == $past(o_table_pointer) - 21'h1)
      else $error("pointer not decremented");
   a_latch_copy: assert property (take |=> o_hold_all[sel_r*8 +: 8] == $past(o_table_latch))
      else $error("holding byte wrong");
   a_byte_lane: assert property (take |=> o_byte_high == ($past(o_table_pointer[0]) ^ $past(md == 2'h3)))
      else $error("byte lane wrong");
   a_flags_kept: assert property ($past(i_rst_n) |-> o_status == $past(i_status_in))
      else $error("status altered");
   a_pc_dummy: assert property (i_instr_valid && !o_busy && i_pc_change |=> s_dummy)
      else $error("no dummy cycle");
   a_word2_skip: assert property (i_instr_valid && !o_busy && i_is_two_word && !i_word2_used |=> o_busy)
      else $error("second word not skipped");
   a_ptr_load: assert property (i_ptr_load && !i_instr_valid && !o_busy |=> o_table_pointer == $past(i_ptr_data))
      else $error("pointer load lost");
endmodule // twh_monitor
bind twh_table_write_unit twh_monitor twh_monitor_inst (.*);
`default_nettype wire

// ===== twh_prog_model.sv
// Programming-side model: scans the holding bank into an image.
// Assumes the bank read answers one cycle after the select.
`timescale 1ns/1ns
`default_nettype none
module twh_prog_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_erase,
   input  wire logic [7:0]  i_rd_data,
   output var  logic        o_clear,
   output var  logic [2:0]  o_rd_sel = 3'h0,
   output var  logic [63:0] o_image
);
   logic [2:0] prev_r;
   always @(posedge i_sys_clk) begin
      o_clear <= i_erase;
      o_rd_sel <= o_rd_sel + 3'h1;
      prev_r <= o_rd_sel;
      o_image[prev_r*8 +: 8] <= i_rd_data;
   end
endmodule // twh_prog_model
`default_nettype wire

// ===== twh_table_write_unit_bench.sv
// Self-checking bench for the table write unit.
// Assumes the checker and programming model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module twh_table_write_unit_bench;
   logic i_sys_clk = 1'b0, i_rst_n = 1'b0, vld = 1'b0, two = 1'b0, pcc = 1'b0;
   logic pld = 1'b0, lld = 1'b0, erase = 1'b0, w2u = 1'b0, clr, busy, no_operation, bh, done;
   logic [15:0] ins = 16'h0000;
   logic [20:0] pdat = 21'h0, ptr, xp;
   logic [7:0]  ldat = 8'h0, st_in = 8'h0, st, lat, rdd;
   logic [2:0]  rsel;
   logic [63:0] all, img, xb;
   logic [20:0] pv [8] = '{21'h00a356, 21'h01389a, 21'h1fffff, 21'h00a357,
                           21'h000007, 21'h1fffff, 21'h000000, 21'h1fffff};
   int n_errors = 0, comparisons = 0;
   always #4 i_sys_clk = ~i_sys_clk;
   twh_table_write_unit twh_table_write_unit_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_instr_valid(vld), .i_instr(ins), .i_is_two_word(two), .i_word2_used(w2u),
      .i_pc_change(pcc), .i_ptr_load(pld), .i_ptr_data(pdat), .i_latch_load(lld),
      .i_latch_data(ldat), .i_status_in(st_in), .i_hold_clear(clr), .i_hold_rd_sel(rsel),
      .o_hold_rd_data(rdd), .o_hold_all(all), .o_table_pointer(ptr), .o_table_latch(lat),
      .o_status(st), .o_byte_high(bh), .o_busy(busy), .o_no_operation(no_operation), .o_write_done(done));
   twh_prog_model twh_prog_model_inst (.i_sys_clk(i_sys_clk), .i_erase(erase),
      .i_rd_data(rdd), .o_clear(clr), .o_rd_sel(rsel), .o_image(img));
   // ====
   // Tasks
   task automatic chk(input string nm, input logic [63:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic setp(input logic [20:0] p, input logic [7:0] l);
      @(posedge i_sys_clk);
      pld <= 1'b1;
      pdat <= p;
      lld <= 1'b1;
      ldat <= l;
      xp = p;
      @(posedge i_sys_clk);
      pld <= 1'b0;
      lld <= 1'b0;
   endtask
   // One word, optionally followed at once by a table write word
   task automatic run(input logic [15:0] w, input logic t, nx, pc);
      @(posedge i_sys_clk);
      vld <= 1'b1;
      ins <= w;
      two <= t;
      pcc <= pc;
      st_in <= st_in + 8'h35;
      @(posedge i_sys_clk);
      vld <= nx;
      ins <= 16'h000e;
      two <= 1'b0;
      pcc <= 1'b0;
      @(posedge i_sys_clk);
      vld <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      chk("status", {56'h0, st_in}, {56'h0, st});
      chk("pointer", {43'h0, xp}, {43'h0, ptr});
      chk("bank", xb, all);
   endtask
   task automatic tw(input logic [1:0] m, input logic nx);
      logic [20:0] s;
      s = (m == 2'h3) ? xp + 21'h1 : xp;
      xb[s[2:0]*8 +: 8] = ldat;
      xp = (m == 2'h2) ? xp - 21'h1 : (m == 2'h0) ? xp : xp + 21'h1;
      run({14'h0003, m}, 1'b0, nx, 1'b0);
      chk("lane", {63'h0, s[0]}, {63'h0, bh});
   endtask
   // ====
   // Main sequence: every mode, wraps, refusal, skips, erase
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      xb = {8{8'hff}};
      chk("reset bank", xb, all);
      chk("reset pointer", 64'h0, {43'h0, ptr});
      for (int i = 0; i < 8; i++) begin
         setp(pv[i], 8'h10 + i[7:0]);
         tw(i[1:0], i == 5);
      end
      run(16'h0f00, 1'b0, 1'b0, 1'b1);
      run(16'hc000, 1'b1, 1'b1, 1'b0);
      // Used second word: the following table write word is taken
      @(posedge i_sys_clk);
      w2u <= 1'b1;
      xb[xp[2:0]*8 +: 8] = ldat;
      xp = xp - 21'h1;
      run(16'hc000, 1'b1, 1'b1, 1'b0);
      w2u <= 1'b0;
      chk("image", xb, img);
      @(posedge i_sys_clk);
      erase <= 1'b1;
      @(posedge i_sys_clk);
      erase <= 1'b0;
      repeat (12) @(posedge i_sys_clk);
      chk("erased image", {8{8'hff}}, img);
      summarize();
   end
   // Watchdog, well past the hundred-odd cycles the tests need
   initial begin
      #20000;
      n_errors++;
      summarize();
   end
endmodule // twh_table_write_unit_bench
`default_nettype wire
